// [pkg/rspc_pkg.sv]
`default_nettype none
package rspc_pkg;
   // Indicator mode field, bits [15:14] of the indicator control register
   localparam int         IND_MODE_HI      = 15;
   localparam int         IND_MODE_LO      = 14;
   localparam logic [1:0] IND_MODE_SPEED   = 2'h0;
   localparam logic [1:0] IND_MODE_ACT     = 2'h1;
   localparam logic [1:0] IND_MODE_RESET   = 2'h0;
   // Speed select bit position in the basic control register
   localparam int         SPEED_SEL_BIT    = 13;
   // Interface-mode strap code for RMII
   localparam logic [2:0] CFG_RMII         = 3'h1;
   // Station address upper bits
   localparam logic [1:0] ADDR_UPPER       = 2'h0;
   // Register port
   localparam int         ADDR_W           = 4;
   localparam logic [3:0] REG_BASIC_CTRL   = 4'h0;
   localparam logic [3:0] REG_IND_CTRL     = 4'h1;
   localparam logic [3:0] REG_STRAP_STAT   = 4'h2;
   localparam logic [3:0] REG_LINK_STAT    = 4'h3;
   localparam logic [15:0] BASIC_CTRL_RST  = 16'h0000;
   localparam int         STRAP_CFG_LO     = 8;
   localparam int         STRAP_BAD_BIT    = 11;
   // Strap sampling: cycles after reset release before straps are taken
   localparam int         CLK_NS           = 25;
   localparam int         STRAP_SETTLE_NS  = 100;
   localparam int         STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] STRAP_SETTLE     = 4'(STRAP_SETTLE_CYC);
   // Activity toggle half period in clock cycles
   localparam int         BLINK_NS         = 50000000;
   localparam int         BLINK_CYC        = BLINK_NS / CLK_NS;
endpackage : rspc_pkg
`default_nettype wire

// [hdl/rspc_sync2.sv]
`default_nettype none
module rspc_sync2
   import rspc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule : rspc_sync2
`default_nettype wire

// [hdl/rspc_rmii_link.sv]
`default_nettype none
module rspc_rmii_link
   import rspc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_ref,
   input  wire logic       tx_en,
   input  wire logic [1:0] txd,
   input  wire logic       rx_valid_in,
   input  wire logic [1:0] rx_dibit_in,
   output var  logic       crs_dv,
   output var  logic [1:0] rxd,
   output var  logic [1:0] tx_dibit,
   output var  logic       tx_valid,
   output var  logic       act_toggle
);
   // MAC inputs are on ref_clk already, taken once per period
   always_ff @(posedge ref_clk) begin
      if (rst_ref) begin
         tx_valid   <= 1'b0;
         tx_dibit   <= 2'h0;
         crs_dv     <= 1'b0;
         rxd        <= 2'h0;
         act_toggle <= 1'b0;
      end else begin
         tx_valid <= tx_en;
         tx_dibit <= tx_en ? txd : 2'h0;
         crs_dv   <= rx_valid_in;
         rxd      <= rx_valid_in ? rx_dibit_in : 2'h0;
         if (tx_en || rx_valid_in) begin
            act_toggle <= ~act_toggle;
         end
      end
   end
endmodule : rspc_rmii_link
`default_nettype wire

// [hdl/rspc_top.sv]
// Overview of operation
// - Indicator mode 00 shows speed (high 10M), 01 shows activity; 10, 11 reserved.
// - Indicator pin sampled after reset release loads speed select, control bit 13.
// - Receive: two bits per reference clock while carrier-sense/data-valid high.
// - Transmit: MAC gives two bits per reference clock while transmit enable high.
// - Station address taken from three address straps at reset; any value 0 to 7 accepted.
// - Station address bits [4:3] are always zero; default straps give 00001.
// - Interface-mode straps latched at reset; only the RMII code is valid.
`default_nettype none
module rspc_top
   import rspc_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input  wire logic              CLOCK,
   input  wire logic              RST,
   input  wire logic              REF_CLK,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [15:0]       WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output var  logic [15:0]       RDATA,
   input  wire logic              SPEED_IND_IN,
   output var  logic              SPEED_IND_OUT,
   output var  logic              SPEED_IND_OE_N,
   input  wire logic [2:0]        ADDR_STRAP_IN,
   output var  logic [2:0]        ADDR_STRAP_OUT,
   output var  logic [2:0]        ADDR_STRAP_OE_N,
   input  wire logic [2:0]        CONFIG_STRAP_IN,
   output var  logic [2:0]        CONFIG_STRAP_OUT,
   output var  logic [2:0]        CONFIG_STRAP_OE_N,
   input  wire logic              TX_EN,
   input  wire logic [1:0]        TXD,
   output var  logic              CRS_DV,
   output var  logic [1:0]        RXD,
   input  wire logic              RX_VALID_IN,
   input  wire logic [1:0]        RX_DIBIT_IN,
   output var  logic [1:0]        TX_DIBIT,
   output var  logic              TX_VALID,
   output var  logic [4:0]        STATION_ADDR,
   output var  logic              RMII_OK
);
   typedef enum logic [1:0] {
      ST_RESET  = 2'h0,
      ST_SETTLE = 2'h1,
      ST_RUN    = 2'h3
   } rspc_state_t;

   rspc_state_t state;
   rspc_state_t next_state;
   logic [3:0]  settle_cnt;
   logic [15:0] basic_ctrl;
   logic [1:0]  ind_mode;
   logic [2:0]  addr_strap;
   logic [2:0]  cfg_strap;
   logic [31:0] blink_cnt;
   logic        blink;
   logic        act_seen;
   logic        act_last;
   logic        act_busy;
   logic [2:0]  rst_ref_sr;
   logic        rst_ref;
   logic        act_tog_link;
   logic        act_tog_sync;
   logic        speed_pin_s;
   logic [2:0]  addr_pin_s;
   logic [2:0]  cfg_pin_s;
   logic        crs_dv_l;
   logic [1:0]  rxd_l;
   logic [1:0]  tx_dibit_l;
   logic        tx_valid_l;

   // Strap pins synchronised before use
   rspc_sync2 #(.W(7)) u_strap_sync (
      .clk (CLOCK),
      .d   ({SPEED_IND_IN, ADDR_STRAP_IN, CONFIG_STRAP_IN}),
      .q   ({speed_pin_s, addr_pin_s, cfg_pin_s})
   );

   // Reset carried into the link domain, held several link edges
   always_ff @(posedge REF_CLK) begin
      rst_ref_sr <= {rst_ref_sr[1:0], RST};
   end
   assign rst_ref = rst_ref_sr[1] | rst_ref_sr[2];

   rspc_rmii_link u_link (
      .ref_clk     (REF_CLK),
      .rst_ref     (rst_ref),
      .tx_en       (TX_EN),
      .txd         (TXD),
      .rx_valid_in (RX_VALID_IN),
      .rx_dibit_in (RX_DIBIT_IN),
      .crs_dv      (crs_dv_l),
      .rxd         (rxd_l),
      .tx_dibit    (tx_dibit_l),
      .tx_valid    (tx_valid_l),
      .act_toggle  (act_tog_link)
   );

   // Link outputs registered on the link clock at the top
   always_ff @(posedge REF_CLK) begin
      CRS_DV   <= crs_dv_l;
      RXD      <= rxd_l;
      TX_DIBIT <= tx_dibit_l;
      TX_VALID <= tx_valid_l;
   end

   // Activity event crosses as a toggle
   rspc_sync2 #(.W(1)) u_act_sync (
      .clk (CLOCK),
      .d   (act_tog_link),
      .q   (act_tog_sync)
   );

   // Strap sequencing: wait for pins to settle, sample, then drive outputs
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET:  next_state = ST_SETTLE;
         ST_SETTLE: if (settle_cnt == STRAP_SETTLE) next_state = ST_RUN;
         ST_RUN:    next_state = ST_RUN;
         default:   next_state = ST_RESET;
      endcase
   end

   wire sample_now = (state == ST_SETTLE) && (settle_cnt == STRAP_SETTLE);
   wire straps_in  = (state != ST_RUN);
   wire wr_basic   = WR && (ADDR == REG_BASIC_CTRL);
   wire wr_ind     = WR && (ADDR == REG_IND_CTRL);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state      <= ST_RESET;
         settle_cnt <= 4'h0;
      end else begin
         state      <= next_state;
         settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 4'h1 : 4'h0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         basic_ctrl <= BASIC_CTRL_RST;
         addr_strap <= 3'h0;
         cfg_strap  <= 3'h0;
      end else if (sample_now) begin
         basic_ctrl[SPEED_SEL_BIT] <= speed_pin_s;
         addr_strap <= addr_pin_s;
         cfg_strap  <= cfg_pin_s;
      end else if (wr_basic) begin
         basic_ctrl <= WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ind_mode <= IND_MODE_RESET;
      end else if (wr_ind) begin
         ind_mode <= WDATA[IND_MODE_HI:IND_MODE_LO];
      end
   end

   // Activity stretch and blink timer
   wire act_evt = act_tog_sync ^ act_last;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         act_last  <= 1'b0;
         act_seen  <= 1'b0;
         act_busy  <= 1'b0;
         blink_cnt <= 32'h0;
         blink     <= 1'b0;
      end else begin
         act_last <= act_tog_sync;
         if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt <= 32'h0;
            act_busy  <= act_seen | act_evt;
            act_seen  <= 1'b0;
            blink     <= (act_seen | act_evt) ? ~blink : 1'b0;
         end else begin
            blink_cnt <= blink_cnt + 32'h1;
            if (act_evt) act_seen <= 1'b1;
         end
      end
   end

   // Indicator: 00 speed (high at 10M), 01 activity (high idle), reserved held high
   wire speed_10m  = ~basic_ctrl[SPEED_SEL_BIT];
   wire ind_level  = (ind_mode == IND_MODE_SPEED) ? speed_10m :
                     (ind_mode == IND_MODE_ACT)   ? ~(act_busy & blink) : 1'b1;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         SPEED_IND_OUT     <= 1'b1;
         SPEED_IND_OE_N    <= 1'b1;
         ADDR_STRAP_OUT    <= 3'h0;
         ADDR_STRAP_OE_N   <= 3'h7;
         CONFIG_STRAP_OUT  <= 3'h0;
         CONFIG_STRAP_OE_N <= 3'h7;
         STATION_ADDR      <= 5'h0;
         RMII_OK           <= 1'b0;
      end else begin
         SPEED_IND_OUT     <= ind_level;
         SPEED_IND_OE_N    <= straps_in;
         ADDR_STRAP_OE_N   <= {3{straps_in}};
         CONFIG_STRAP_OE_N <= {3{straps_in}};
         ADDR_STRAP_OUT    <= 3'h0;
         CONFIG_STRAP_OUT  <= 3'h0;
         STATION_ADDR      <= {ADDR_UPPER, addr_strap};
         RMII_OK           <= (cfg_strap == CFG_RMII) && !straps_in;
      end
   end

   // Register reads; unmapped addresses read zero
   wire [15:0] rd_mux =
      (ADDR == REG_BASIC_CTRL) ? basic_ctrl :
      (ADDR == REG_IND_CTRL)   ? {ind_mode, 14'h0} :
      (ADDR == REG_STRAP_STAT) ? {4'h0, (cfg_strap != CFG_RMII), cfg_strap,
                                  3'h0, ADDR_UPPER, addr_strap} :
      (ADDR == REG_LINK_STAT)  ? {14'h0, act_busy, (state == ST_RUN)} : 16'h0;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RDATA <= 16'h0;
      end else begin
         RDATA <= RD ? rd_mux : 16'h0;
      end
   end
endmodule : rspc_top
`default_nettype wire

// [test/rspc_asserts.sv]
`default_nettype none
module rspc_asserts
   import rspc_pkg::*;
(
   input wire logic       CLOCK,
   input wire logic       RST,
   input wire logic       REF_CLK,
   input wire logic       TX_EN,
   input wire logic [1:0] TXD,
   input wire logic       RX_VALID_IN,
   input wire logic [1:0] RX_DIBIT_IN,
   input wire logic       CRS_DV,
   input wire logic [1:0] RXD,
   input wire logic       TX_VALID,
   input wire logic [1:0] TX_DIBIT,
   input wire logic       SPEED_IND_OE_N,
   input wire logic [2:0] ADDR_STRAP_OE_N,
   input wire logic [2:0] CONFIG_STRAP_OE_N,
   input wire logic [4:0] STATION_ADDR,
   input wire logic       RMII_OK
);
   timeunit 1ns;
   timeprecision 100ps;
   a_tx_dibit_pass: assert property (@(posedge REF_CLK) disable iff (RST)
      TX_EN |-> ##2 TX_VALID && TX_DIBIT == $past(TXD, 2)) else $error("tx dibit lost");
   a_tx_idle_low: assert property (@(posedge REF_CLK) disable iff (RST)
      !TX_EN |-> ##2 !TX_VALID && TX_DIBIT == 2'h0) else $error("tx not idle");
   a_rx_dibit_pass: assert property (@(posedge REF_CLK) disable iff (RST)
      RX_VALID_IN |-> ##2 CRS_DV && RXD == $past(RX_DIBIT_IN, 2)) else $error("rx dibit lost");
   a_rx_idle_low: assert property (@(posedge REF_CLK) disable iff (RST)
      !RX_VALID_IN |-> ##2 !CRS_DV && RXD == 2'h0) else $error("rx not idle");
   a_reset_pins_input: assert property (@(posedge CLOCK)
      RST |=> SPEED_IND_OE_N && &ADDR_STRAP_OE_N && &CONFIG_STRAP_OE_N)
      else $error("strap pins driven in reset");
   a_pins_become_outputs: assert property (@(posedge CLOCK) disable iff (RST)
      $fell(RST) |-> ##[1:10] !SPEED_IND_OE_N && ADDR_STRAP_OE_N == 3'h0
         && CONFIG_STRAP_OE_N == 3'h0) else $error("pins not released to outputs");
   a_addr_held: assert property (@(posedge CLOCK) disable iff (RST)
      !ADDR_STRAP_OE_N[0] |=> $stable(STATION_ADDR)) else $error("address follows pin");
   a_addr_upper_zero: assert property (@(posedge CLOCK) disable iff (RST)
      !ADDR_STRAP_OE_N[0] |-> STATION_ADDR[4:3] == ADDR_UPPER) else $error("address upper set");
   a_mode_held: assert property (@(posedge CLOCK) disable iff (RST)
      !CONFIG_STRAP_OE_N[0] |=> $stable(RMII_OK)) else $error("mode follows pin");
endmodule : rspc_asserts
bind rspc_top rspc_asserts u_chk (.CLOCK, .RST, .REF_CLK, .TX_EN, .TXD, .RX_VALID_IN,
   .RX_DIBIT_IN, .CRS_DV, .RXD, .TX_VALID, .TX_DIBIT, .SPEED_IND_OE_N, .ADDR_STRAP_OE_N,
   .CONFIG_STRAP_OE_N, .STATION_ADDR, .RMII_OK);
`default_nettype wire

// [test/rspc_mac_model.sv]
`default_nettype none
module rspc_mac_model (
   input  wire logic        ref_clk,
   input  wire logic        go,
   input  wire logic [15:0] word,
   input  wire logic        crs_dv,
   input  wire logic [1:0]  rxd,
   output wire logic        tx_en,
   output wire logic [1:0]  txd,
   output var  logic [15:0] rx_word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        en  = 1'b0;
   logic [1:0]  d   = 2'h0;
   logic [15:0] sh  = 16'h0000;
   logic [3:0]  cnt = 4'h0;
   assign tx_en = en;
   assign txd   = d;
   always @(posedge ref_clk) begin
      if (crs_dv)
         rx_word <= {rxd, rx_word[15:2]};
      if (cnt != 4'h0) begin
         en  <= 1'b1;
         d   <= sh[1:0];
         sh  <= sh >> 2;
         cnt <= cnt - 4'h1;
      end else begin
         en <= 1'b0;
         // Idle data keeps changing so nothing relies on stale bits
         d  <= ~d;
         if (go) begin
            sh  <= word;
            cnt <= 4'h8;
         end
      end
   end
endmodule : rspc_mac_model
`default_nettype wire

// [test/rspc_top_test.sv]
`default_nettype none
module rspc_top_test
   import rspc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic        CLOCK = 1'b0, REF_CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
   logic        s_spd = 1'b1, go = 1'b0, SPEED_IND_OUT, SPEED_IND_OE_N, TX_EN, CRS_DV;
   logic        TX_VALID, RMII_OK;
   logic [1:0]  TXD, RXD, TX_DIBIT;
   logic [2:0]  s_addr = 3'h1, s_cfg = 3'h1, ADDR_STRAP_OUT, ADDR_STRAP_OE_N;
   logic [2:0]  CONFIG_STRAP_OUT, CONFIG_STRAP_OE_N;
   logic [3:0]  ADDR = 4'h0;
   logic [4:0]  STATION_ADDR;
   logic [15:0] WDATA = 16'h0000, RDATA, word = 16'h0000, rx_word;
   int          n_mismatch = 0, total_checks = 0, k;
   // Pin levels resolved from whoever drives them
   wire logic       SPEED_IND_IN = SPEED_IND_OE_N ? s_spd : SPEED_IND_OUT;
   wire logic [2:0] ADDR_STRAP_IN = (ADDR_STRAP_OE_N & s_addr)
                                   | (~ADDR_STRAP_OE_N & ADDR_STRAP_OUT);
   wire logic [2:0] CONFIG_STRAP_IN = (CONFIG_STRAP_OE_N & s_cfg)
                                     | (~CONFIG_STRAP_OE_N & CONFIG_STRAP_OUT);
   // Media side loops transmit back to receive
   wire logic       RX_VALID_IN = TX_VALID;
   wire logic [1:0] RX_DIBIT_IN = TX_DIBIT;
   rspc_top #(.BLINK_CYCLES(8)) DUT (.CLOCK, .RST, .REF_CLK, .ADDR, .WDATA, .WR, .RD, .RDATA,
      .SPEED_IND_IN, .SPEED_IND_OUT, .SPEED_IND_OE_N, .ADDR_STRAP_IN, .ADDR_STRAP_OUT,
      .ADDR_STRAP_OE_N, .CONFIG_STRAP_IN, .CONFIG_STRAP_OUT, .CONFIG_STRAP_OE_N, .TX_EN, .TXD,
      .CRS_DV, .RXD, .RX_VALID_IN, .RX_DIBIT_IN, .TX_DIBIT, .TX_VALID, .STATION_ADDR, .RMII_OK);
   rspc_mac_model mac (.ref_clk(REF_CLK), .go(go), .word(word), .crs_dv(CRS_DV), .rxd(RXD),
      .tx_en(TX_EN), .txd(TXD), .rx_word(rx_word));
   initial forever #12.5 CLOCK = ~CLOCK;
   initial begin
      #7;
      forever #62.5 REF_CLK = ~REF_CLK;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLOCK) WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
      @(posedge CLOCK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLOCK) RD <= 1'b0;
      #1 chk(n, e, RDATA);
   endtask : rd
   task automatic t_strap(input logic [2:0] a, input logic [2:0] c, input logic s);
      logic [15:0] st;
      st = {4'h0, c != CFG_RMII, c, 3'h0, ADDR_UPPER, a};
      @(posedge CLOCK);
      s_addr <= a;
      s_cfg  <= c;
      s_spd  <= s;
      RST    <= 1'b1;
      repeat (20) @(posedge CLOCK);
      RST <= 1'b0;
      for (k = 0; k < 40 && SPEED_IND_OE_N !== 1'b0; k++) @(posedge CLOCK);
      if (k == 40) begin
         $display("mismatch oe_release expected 0 seen 1");
         n_mismatch++;
         complete_run();
      end
      rd(REG_STRAP_STAT, st, "strap");
      wr(REG_STRAP_STAT, 16'hFFFF);
      rd(REG_STRAP_STAT, st, "strap_ro");
      rd(REG_BASIC_CTRL, {2'h0, s, 13'h0000}, "speed_sel");
      chk("addr", {11'h000, ADDR_UPPER, a}, {11'h000, STATION_ADDR});
      chk("rmii", {15'h0000, c == CFG_RMII}, {15'h0000, RMII_OK});
      chk("oe", 16'h0000, {9'h000, ADDR_STRAP_OE_N, CONFIG_STRAP_OE_N, SPEED_IND_OE_N});
      chk("strap_out", 16'h0000, {10'h000, ADDR_STRAP_OUT, CONFIG_STRAP_OUT});
      chk("ind_speed", {15'h0000, ~s}, {15'h0000, SPEED_IND_OUT});
   endtask : t_strap
   task automatic t_link(input logic [15:0] w);
      @(posedge REF_CLK);
      word <= w;
      go   <= 1'b1;
      @(posedge REF_CLK) go <= 1'b0;
      repeat (16) @(posedge REF_CLK);
      #1 chk("loop", w, rx_word);
   endtask : t_link
   task automatic t_ind;
      int   n;
      logic p;
      n = 0;
      p = 1'b1;
      wr(REG_IND_CTRL, {IND_MODE_ACT, 14'h0000});
      rd(REG_IND_CTRL, {IND_MODE_ACT, 14'h0000}, "mode");
      repeat (60) @(posedge CLOCK);
      chk("ind_idle", 16'h0001, {15'h0000, SPEED_IND_OUT});
      fork
         t_link(16'hA5C3);
         repeat (80) begin
            @(posedge CLOCK);
            n += int'(SPEED_IND_OUT !== p);
            p = SPEED_IND_OUT;
         end
      join
      chk("ind_blink", 16'h0001, {15'h0000, n > 1});
      for (k = 2; k < 4; k++) begin
         wr(REG_IND_CTRL, {2'(k), 14'h0000});
         repeat (4) @(posedge CLOCK);
         chk("ind_rsvd", 16'h0001, {15'h0000, SPEED_IND_OUT});
      end
   endtask : t_ind
   initial begin
      repeat (12) @(posedge CLOCK);
      RST <= 1'b0;
      repeat (20) @(posedge CLOCK);
      for (int i = 7; i >= 0; i--) t_strap(3'(i), 3'(i), i[0]);
      t_strap(3'h1, CFG_RMII, 1'b1);
      t_link(16'h1E2D);
      t_ind();
      rd(4'hF, 16'h0000, "unmapped");
      complete_run();
   end
endmodule : rspc_top_test
`default_nettype wire
